// [design/dpsc_defs.svh]
// Timing counts, field positions and reset values of the pot command decoder.
`ifndef DPSC_DEFS_SVH
`define DPSC_DEFS_SVH
`define DPSC_FRAME_BITS 24
`define DPSC_OPC_HI 23
`define DPSC_OPC_LO 20
`define DPSC_ADR_HI 19
`define DPSC_ADR_LO 16
`define DPSC_DAT_HI 15
`define DPSC_WIPER_BITS 10
`define DPSC_WIPER_MAX 10'h3ff
`define DPSC_WIPER_MID 10'h200
`define DPSC_NV_RESET 16'h0200
`define DPSC_CLK_MHZ 10
`define DPSC_STORE_MS 15
`define DPSC_STORE_CYC (`DPSC_STORE_MS * 1000 * `DPSC_CLK_MHZ)
`define DPSC_NV_DEPTH 16
`endif

// [design/dpsc_pkg.sv]
// Types shared by the pot command decoder files.
package dpsc_pkg;
    typedef enum logic [3:0] {
        OP_NOP, OP_RESTORE, OP_STORE_WIPER, OP_STORE_DATA,
        OP_SHR_ONE, OP_SHR_ALL, OP_DEC_ONE, OP_DEC_ALL,
        OP_RELOAD_ALL, OP_READ_NV, OP_READ_WIPER, OP_WRITE_WIPER,
        OP_SHL_ONE, OP_SHL_ALL, OP_INC_ONE, OP_INC_ALL
    } dpsc_op_t;
    typedef enum logic [2:0] {
        ST_BOOT0, ST_BOOT1, ST_IDLE, ST_LOAD0, ST_LOAD1, ST_STORE
    } dpsc_state_t;
endpackage

// [design/dpsc_nv_mem.sv]
// Sixteen-word nonvolatile store model with registered read data.
`timescale 1ns/1ps
`include "dpsc_defs.svh"
module dpsc_nv_mem (
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    input wire logic i_wr,
    input wire logic [3:0] i_addr,
    input wire logic [15:0] i_wdata,
    output logic [15:0] o_rdata
);
    logic [15:0] mem [0:`DPSC_NV_DEPTH-1];

    // Contents start at midscale, standing in for the factory preset.
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            for (int i = 0; i < `DPSC_NV_DEPTH; i++) begin
                mem[i] <= `DPSC_NV_RESET;
            end
        end else if (i_wr) begin
            mem[i_addr] <= i_wdata;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rdata <= 16'h0000;
        end else begin
            o_rdata <= mem[i_addr];
        end
    end
endmodule

// [design/dpsc_core.sv]
// Serial command decoder for a dual ten-bit nonvolatile potentiometer.
`timescale 1ns/1ps
`include "dpsc_defs.svh"
module dpsc_core #(
    parameter int STORE_CYCLES = `DPSC_STORE_CYC
) (
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    input wire logic i_sclk,
    input wire logic i_csel_n,
    input wire logic i_serial_in_pin,
    output logic o_serial_out_pin,
    output logic o_serial_out_oe_n,
    output logic o_ready,
    output logic [9:0] o_wiper0,
    output logic [9:0] o_wiper1
);
    ////////////////////////////////////////////////////////////////////
    function automatic logic [9:0] dpsc_shl(input logic [9:0] v);
        if (v == 10'h000) begin
            return 10'h001;
        end else if (v >= `DPSC_WIPER_MID) begin
            return `DPSC_WIPER_MAX;
        end else begin
            return {v[8:0], 1'b0};
        end
    endfunction

    function automatic logic [9:0] dpsc_step(input dpsc_pkg::dpsc_op_t op,
                                             input logic [9:0] v);
        logic [9:0] r;
        r = v;
        case (op)
            dpsc_pkg::OP_SHR_ONE, dpsc_pkg::OP_SHR_ALL: begin
                r = {1'b0, v[9:1]};
            end
            dpsc_pkg::OP_DEC_ONE, dpsc_pkg::OP_DEC_ALL: begin
                if (v != 10'h000) begin
                    r = v - 10'h001;
                end
            end
            dpsc_pkg::OP_SHL_ONE, dpsc_pkg::OP_SHL_ALL: begin
                r = dpsc_shl(v);
            end
            dpsc_pkg::OP_INC_ONE, dpsc_pkg::OP_INC_ALL: begin
                if (v != `DPSC_WIPER_MAX) begin
                    r = v + 10'h001;
                end
            end
            default: begin
                r = v;
            end
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers.
    logic [1:0] sclk_sync;
    logic [1:0] csel_sync;
    logic [1:0] sdi_sync;
    logic sclk_prev;
    logic csel_prev;

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sclk_sync <= 2'h0;
            csel_sync <= 2'h3;
            sdi_sync <= 2'h0;
            sclk_prev <= 1'b0;
            csel_prev <= 1'b1;
        end else begin
            sclk_sync <= {sclk_sync[0], i_sclk};
            csel_sync <= {csel_sync[0], i_csel_n};
            sdi_sync <= {sdi_sync[0], i_serial_in_pin};
            sclk_prev <= sclk_sync[1];
            csel_prev <= csel_sync[1];
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic csel_low;
    logic csel_rise;
    assign csel_low = !csel_sync[1];
    assign sclk_rise = csel_low && sclk_sync[1] && !sclk_prev;
    assign sclk_fall = csel_low && !sclk_sync[1] && sclk_prev;
    assign csel_rise = csel_sync[1] && !csel_prev;

    ////////////////////////////////////////////////////////////////////
    // Control state.
    dpsc_pkg::dpsc_state_t state;
    logic [23:0] shreg;
    logic [23:0] outreg;
    logic [23:0] last_cmd;
    logic [5:0] bit_cnt;
    logic [23:0] store_cnt;
    logic [15:0] nv_rdata;
    logic nv_wr;
    logic [3:0] nv_addr;
    logic [15:0] nv_wdata;
    logic load_both;
    logic load_chan;
    logic rb_pend;
    logic [15:0] rb_val;
    logic rb_fetch;

    logic locked;
    assign locked = (state == dpsc_pkg::ST_STORE);

    // Frame accepted at chip select rise: multiple of four, and either a
    // fresh frame or a bare strobe that repeats the previous command.
    logic frame_ok;
    logic [23:0] exec_word;
    assign frame_ok = csel_rise && (bit_cnt[1:0] == 2'h0) && !locked;
    assign exec_word = (bit_cnt == 6'h00) ? last_cmd : shreg;

    dpsc_pkg::dpsc_op_t op;
    logic [3:0] adr;
    logic [15:0] dat;
    logic sel;
    assign op = dpsc_pkg::dpsc_op_t'(exec_word[`DPSC_OPC_HI:`DPSC_OPC_LO]);
    assign adr = exec_word[`DPSC_ADR_HI:`DPSC_ADR_LO];
    assign dat = exec_word[`DPSC_DAT_HI:0];
    assign sel = adr[0];

    ////////////////////////////////////////////////////////////////////
    // Input shifter; frozen while a store runs.
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            shreg <= 24'h000000;
            bit_cnt <= 6'h00;
            last_cmd <= 24'h000000;
        end else if (locked) begin
            bit_cnt <= 6'h00;
        end else if (csel_rise) begin
            if (bit_cnt[1:0] == 2'h0 && bit_cnt != 6'h00) begin
                last_cmd <= shreg;
            end
            bit_cnt <= 6'h00;
        end else if (sclk_rise) begin
            shreg <= {shreg[22:0], sdi_sync[1]};
            if (bit_cnt != 6'h3f) begin
                bit_cnt <= bit_cnt + 6'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Output shifter: holds the previous frame, launched on falling edges.
    // It takes in the bit just clocked in, so that a longer frame passes
    // straight through to the next device in a chain, one frame late.
    logic out_started;
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            outreg <= 24'h000000;
            out_started <= 1'b0;
        end else if (csel_rise) begin
            outreg <= shreg;
            out_started <= 1'b0;
        end else if (rb_fetch) begin
            outreg[15:0] <= rb_val;
        end else if (sclk_rise) begin
            out_started <= 1'b1;
        end else if (sclk_fall && out_started) begin
            outreg <= {outreg[22:0], shreg[0]};
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_serial_out_pin <= 1'b1;
            o_serial_out_oe_n <= 1'b1;
        end else begin
            o_serial_out_pin <= outreg[23];
            o_serial_out_oe_n <= !csel_low;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Command execution, boot load and store timing.
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state <= dpsc_pkg::ST_BOOT0;
            o_wiper0 <= `DPSC_WIPER_MID;
            o_wiper1 <= `DPSC_WIPER_MID;
            nv_wr <= 1'b0;
            nv_addr <= 4'h0;
            nv_wdata <= 16'h0000;
            store_cnt <= 24'h000000;
            o_ready <= 1'b1;
            load_both <= 1'b1;
            load_chan <= 1'b0;
            rb_pend <= 1'b0;
            rb_val <= 16'h0000;
            rb_fetch <= 1'b0;
        end else begin
            nv_wr <= 1'b0;
            o_ready <= 1'b1;
            rb_fetch <= 1'b0;
            case (state)
                dpsc_pkg::ST_BOOT0: begin
                    nv_addr <= 4'h0;
                    load_both <= 1'b1;
                    state <= dpsc_pkg::ST_LOAD0;
                end
                dpsc_pkg::ST_LOAD0: begin
                    state <= dpsc_pkg::ST_LOAD1;
                end
                dpsc_pkg::ST_LOAD1: begin
                    if (rb_pend) begin
                        rb_val <= nv_rdata;
                        rb_fetch <= 1'b1;
                        rb_pend <= 1'b0;
                        state <= dpsc_pkg::ST_IDLE;
                    end else if (nv_addr == 4'h0 && !(load_chan && !load_both))
                    begin
                        o_wiper0 <= nv_rdata[9:0];
                        if (load_both) begin
                            nv_addr <= 4'h1;
                            state <= dpsc_pkg::ST_LOAD0;
                        end else begin
                            state <= dpsc_pkg::ST_IDLE;
                        end
                    end else begin
                        o_wiper1 <= nv_rdata[9:0];
                        state <= dpsc_pkg::ST_IDLE;
                    end
                end
                dpsc_pkg::ST_STORE: begin
                    if (store_cnt == 24'(STORE_CYCLES - 1)) begin
                        o_ready <= 1'b0;
                        state <= dpsc_pkg::ST_IDLE;
                    end else begin
                        store_cnt <= store_cnt + 24'h000001;
                    end
                end
                dpsc_pkg::ST_IDLE: begin
                    if (frame_ok) begin
                        load_both <= 1'b0;
                        case (op)
                            dpsc_pkg::OP_NOP: begin
                            end
                            dpsc_pkg::OP_RESTORE: begin
                                if (adr[3:1] == 3'h0) begin
                                    nv_addr <= {3'h0, sel};
                                    load_chan <= sel;
                                    state <= dpsc_pkg::ST_LOAD0;
                                end
                            end
                            dpsc_pkg::OP_STORE_WIPER: begin
                                nv_addr <= {3'h0, sel};
                                nv_wdata <= {6'h00, sel ? o_wiper1 : o_wiper0};
                                nv_wr <= 1'b1;
                                store_cnt <= 24'h000000;
                                state <= dpsc_pkg::ST_STORE;
                            end
                            dpsc_pkg::OP_STORE_DATA: begin
                                nv_addr <= adr;
                                nv_wdata <= dat;
                                nv_wr <= 1'b1;
                                store_cnt <= 24'h000000;
                                state <= dpsc_pkg::ST_STORE;
                            end
                            dpsc_pkg::OP_RELOAD_ALL: begin
                                if (adr == 4'h0) begin
                                    nv_addr <= 4'h0;
                                    load_both <= 1'b1;
                                    load_chan <= 1'b0;
                                    state <= dpsc_pkg::ST_LOAD0;
                                end
                            end
                            dpsc_pkg::OP_READ_NV: begin
                                nv_addr <= adr;
                                rb_pend <= 1'b1;
                                state <= dpsc_pkg::ST_LOAD0;
                            end
                            dpsc_pkg::OP_READ_WIPER: begin
                                rb_val <= {6'h00, sel ? o_wiper1 : o_wiper0};
                                rb_fetch <= 1'b1;
                            end
                            dpsc_pkg::OP_WRITE_WIPER: begin
                                if (sel) begin
                                    o_wiper1 <= dat[9:0];
                                end else begin
                                    o_wiper0 <= dat[9:0];
                                end
                            end
                            dpsc_pkg::OP_SHR_ALL, dpsc_pkg::OP_DEC_ALL,
                            dpsc_pkg::OP_SHL_ALL, dpsc_pkg::OP_INC_ALL: begin
                                o_wiper0 <= dpsc_step(op, o_wiper0);
                                o_wiper1 <= dpsc_step(op, o_wiper1);
                            end
                            default: begin
                                if (sel) begin
                                    o_wiper1 <= dpsc_step(op, o_wiper1);
                                end else begin
                                    o_wiper0 <= dpsc_step(op, o_wiper0);
                                end
                            end
                        endcase
                    end
                end
                default: begin
                    state <= dpsc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    dpsc_nv_mem u_nv (
        .i_core_clk(i_core_clk),
        .i_arst_n(i_arst_n),
        .i_wr(nv_wr),
        .i_addr(nv_addr),
        .i_wdata(nv_wdata),
        .o_rdata(nv_rdata)
    );
endmodule

// [verif/dpsc_core_asserts.sv]
// Port-level timing checks for the pot command decoder.
`timescale 1ns/1ps
module dpsc_core_asserts #(
    parameter int STORE_CYCLES = 150000
) (
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    input wire logic i_sclk,
    input wire logic i_csel_n,
    input wire logic i_serial_in_pin,
    input wire logic o_serial_out_pin,
    input wire logic o_serial_out_oe_n,
    input wire logic o_ready,
    input wire logic [9:0] o_wiper0,
    input wire logic [9:0] o_wiper1
);
    logic cs_q;
    logic sclk_q;
    logic [3:0] since_rise;
    logic [3:0] since_fall;
    logic [3:0] low_cnt;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);
    ////////////////////////////////////////////////////////////////////////
    // Counters saturate so long idle spans cannot wrap into a false window.
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cs_q <= 1'b1;
            sclk_q <= 1'b0;
            since_rise <= 4'h0;
            since_fall <= 4'hf;
            low_cnt <= 4'h0;
        end else begin
            cs_q <= i_csel_n;
            sclk_q <= i_sclk;
            if (i_csel_n && !cs_q) since_rise <= 4'h0;
            else if (since_rise != 4'hf) since_rise <= since_rise + 4'h1;
            if (!i_sclk && sclk_q) since_fall <= 4'h0;
            else if (since_fall != 4'hf) since_fall <= since_fall + 4'h1;
            if (i_csel_n) low_cnt <= 4'h0;
            else if (low_cnt != 4'hf) low_cnt <= low_cnt + 4'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    sequence cs_idle;
        i_csel_n [*6];
    endsequence
    sequence cs_busy;
        !i_csel_n [*6];
    endsequence
    a_ready_pulse: assert property ($fell(o_ready) |=> o_ready)
        else $error("ready low longer than one cycle");
    a_oe_low_sel: assert property (cs_busy |-> !o_serial_out_oe_n)
        else $error("output not enabled in frame");
    a_oe_high_idle: assert property (cs_idle |-> o_serial_out_oe_n)
        else $error("output enabled while idle");
    a_oe_fall_bound: assert property ($fell(i_csel_n) |->
        ##[1:5] !o_serial_out_oe_n) else $error("output enable late");
    a_oe_rise_bound: assert property ($rose(i_csel_n) |->
        ##[1:5] o_serial_out_oe_n) else $error("output release late");
    a_wiper_window: assert property (
        ($changed(o_wiper0) || $changed(o_wiper1)) |-> since_rise < 4'hd)
        else $error("wiper moved away from frame end");
    a_wiper_quiet: assert property (low_cnt == 4'hf |->
        $stable(o_wiper0) && $stable(o_wiper1)) else $error("wiper moved");
    a_sdo_on_fall: assert property (
        ($changed(o_serial_out_pin) && low_cnt > 4'h6) |-> since_fall < 4'h5)
        else $error("serial out moved off a clock fall");
endmodule
bind dpsc_core dpsc_core_asserts #(.STORE_CYCLES(STORE_CYCLES)) i_chk (
    .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_sclk(i_sclk),
    .i_csel_n(i_csel_n), .i_serial_in_pin(i_serial_in_pin),
    .o_serial_out_pin(o_serial_out_pin), .o_ready(o_ready),
    .o_serial_out_oe_n(o_serial_out_oe_n),
    .o_wiper0(o_wiper0), .o_wiper1(o_wiper1));

// [verif/dpsc_host.sv]
// Host serial master that frames and clocks command words.
`timescale 1ns/1ps
module dpsc_host (
    input wire logic i_clk,
    input wire logic i_sdo,
    output logic o_sclk,
    output logic o_csel_n,
    output logic o_sdi
);
    initial begin
        o_sclk = 1'b0;
        o_csel_n = 1'b1;
        o_sdi = 1'b0;
    end
    task automatic xfer(input logic [47:0] d, input int n,
                        output logic [47:0] q);
        q = 48'h0;
        @(negedge i_clk);
        o_csel_n = 1'b0;
        repeat (8) @(negedge i_clk);
        for (int i = n - 1; i >= 0; i--) begin
            o_sdi = d[i];
            repeat (4) @(negedge i_clk);
            o_sclk = 1'b1;
            q = {q[46:0], i_sdo};
            repeat (4) @(negedge i_clk);
            o_sclk = 1'b0;
        end
        repeat (4) @(negedge i_clk);
        o_csel_n = 1'b1;
        // A released data line must not keep showing the last bit.
        o_sdi = ~o_sdi;
        repeat (16) @(negedge i_clk);
    endtask
endmodule

// [verif/tb.sv]
// Self-checking bench for the pot command decoder.
`timescale 1ns/1ps
module tb;
    localparam int STORE_CYC = 400;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sclk;
    logic csel_n;
    logic serial_in_pin;
    logic serial_out_pin;
    logic oe_n;
    logic rdy;
    logic [9:0] wip0;
    logic [9:0] wip1;
    wire sdo_line = oe_n ? 1'b1 : serial_out_pin;
    int fail_count = 0;
    int check_count = 0;
    int w[2];
    int nv[16];
    logic [23:0] prev;
    logic [23:0] lastf;
    bit skip;
    bit storing;
    always #50 clk = ~clk;
    dpsc_core #(.STORE_CYCLES(STORE_CYC)) i_dpsc_core (
        .i_core_clk(clk), .i_arst_n(rst_n), .i_sclk(sclk),
        .i_csel_n(csel_n), .i_serial_in_pin(serial_in_pin), .o_serial_out_pin(serial_out_pin),
        .o_serial_out_oe_n(oe_n), .o_ready(rdy),
        .o_wiper0(wip0), .o_wiper1(wip1));
    dpsc_host i_dpsc_host (.i_clk(clk), .i_sdo(sdo_line), .o_sclk(sclk),
        .o_csel_n(csel_n), .o_sdi(serial_in_pin));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    function automatic int step(int op, int v);
        case (op)
            4, 5: return v >> 1;
            6, 7: return (v > 0) ? v - 1 : v;
            12, 13: return (v == 0) ? 1 : (v >= 512) ? 1023 : v << 1;
            14, 15: return (v < 1023) ? v + 1 : v;
            default: return v;
        endcase
    endfunction
    task automatic do_reset();
        rst_n = 1'b0;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        foreach (nv[i]) nv[i] = 'h200;
        w = '{'h200, 'h200};
        skip = 1;
        storing = 0;
        lastf = 24'h0;
        repeat (12) @(negedge clk);
        chk({38'h0, wip0}, 48'(w[0]));
        chk({38'h0, wip1}, 48'(w[1]));
    endtask
    // Frames that are cut short or land in a store leave the next readout
    // undefined, so its comparison is skipped rather than guessed.
    task automatic cmd(input logic [47:0] d, input int n);
        logic [47:0] q;
        logic [23:0] f;
        int op;
        int a;
        int c;
        f = (n == 0) ? lastf : d[23:0];
        i_dpsc_host.xfer(d, n, q);
        if (!skip && n == 24) chk(q, {24'h0, prev});
        if (!skip && n == 48) chk(q, {prev, d[47:24]});
        skip = !(n == 24 || n == 48) || storing;
        if (n % 4 == 0 && !storing) begin
            prev = f;
            lastf = f;
            op = f[23:20];
            a = f[19:16];
            c = a % 2;
            case (op)
                1: if (a < 2) w[c] = nv[c] % 1024;
                2: nv[c] = w[c];
                3: nv[a] = f[15:0];
                8: if (a == 0) w = '{nv[0] % 1024, nv[1] % 1024};
                9: prev[15:0] = 16'(nv[a]);
                10: prev[15:0] = 16'(w[c]);
                11: w[c] = f[9:0];
                5, 7, 13, 15: w = '{step(op, w[0]), step(op, w[1])};
                4, 6, 12, 14: w[c] = step(op, w[c]);
                default: ;
            endcase
            storing = (op == 2 || op == 3);
        end
        chk({38'h0, wip0}, 48'(w[0]));
        chk({38'h0, wip1}, 48'(w[1]));
    endtask
    task automatic wait_ready(output int k);
        k = 0;
        while (rdy !== 1'b0 && k < 1000) begin
            @(negedge clk);
            k++;
        end
        chk({47'h0, rdy}, 48'h0);
        storing = 0;
        @(negedge clk);
        chk({47'h0, rdy}, 48'h1);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        int v[3][2];
        int ops[8];
        int k;
        v = '{'{0, 1023}, '{512, 1}, '{511, 1022}};
        ops = '{4, 5, 6, 7, 12, 13, 14, 15};
        void'($urandom(32'h386e));
        do_reset();
        for (int i = 0; i < 6; i++) begin
            cmd({28'hb, 3'h0, 1'($urandom), 16'($urandom)}, 24);
        end
        foreach (v[j]) begin
            foreach (ops[o]) begin
                cmd({24'h0, 8'hb0, 6'($urandom), 10'(v[j][0])}, 24);
                cmd({24'h0, 8'hb1, 6'h0, 10'(v[j][1])}, 24);
                cmd({24'h0, 4'(ops[o]), 4'($urandom % 2),
                     16'($urandom)}, 24);
            end
        end
        cmd({32'h0, 16'($urandom)}, 24);
        cmd({24'h0, 8'ha1, 16'h0}, 24);
        for (int a = 2; a < 15; a += 4) begin
            cmd({28'h3, 4'(a), 16'($urandom)}, 24);
            wait_ready(k);
            cmd({28'h9, 4'(a), 16'h0}, 24);
        end
        cmd({24'h0, 8'h30, 16'($urandom)}, 24);
        wait_ready(k);
        chk(48'(k >= STORE_CYC - 15 && k <= STORE_CYC - 8), 48'h1);
        cmd({24'h0, 8'h12, 16'h0}, 24);
        cmd({24'h0, 8'h10, 16'h0}, 24);
        cmd({24'h0, 8'h21, 16'h0}, 24);
        cmd({24'h0, 8'hb1, 16'h0155}, 24);
        wait_ready(k);
        cmd({24'h0, 8'hf0, 16'h0}, 24);
        cmd({24'h0, 8'h81, 16'h0}, 24);
        cmd({24'h0, 8'h80, 16'h0}, 24);
        cmd({24'h0, 8'h90, 16'h0}, 24);
        cmd({24'h0, 8'he1, 16'h0}, 22);
        cmd({24'h0, 8'he1, 16'h0}, 24);
        cmd({8'he0, 16'h0, 8'h60, 16'h0}, 48);
        cmd(48'h0, 0);
        cmd({24'h0, 8'ha0, 16'h0}, 24);
        cmd({24'h0, 8'h00, 16'h0}, 24);
        do_reset();
        complete_run();
    end
    initial begin
        repeat (90000) @(posedge clk);
        fail_count++;
        complete_run();
    end
endmodule
